// ### rtl/tc_pkg.sv
/*
  Package of the 16-bit timer/counter: register map, control fields,
  reset values and the carrier structs shared by the design.
  Assumes an 8-bit register port with a 3-bit word address.
*/
package tc_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [2:0] TC_OFS_CTRL = 3'h0;
  localparam logic [2:0] TC_OFS_CNT_LO = 3'h1;
  localparam logic [2:0] TC_OFS_CNT_HI = 3'h2;
  localparam logic [2:0] TC_OFS_IRQ_FLAGS = 3'h3;
  localparam logic [2:0] TC_OFS_IRQ_ENABLES = 3'h4;
  localparam logic [2:0] TC_OFS_OSC_CTRL = 3'h5;
  localparam logic [2:0] TC_OFS_PORT_DIR = 3'h6;
  localparam logic [2:0] TC_OFS_PORT_DATA = 3'h7;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int TC_BIT_OVF = 0;
  localparam int TC_BIT_RUN = 6;
  localparam logic [7:0] TC_CTRL_RST = 8'h00;
  localparam logic [1:0] TC_DIR_RST = 2'h3;
  localparam logic [1:0] TC_SCS_RST = 2'h0;
  localparam logic [1:0] TC_SCS_TIMER_OSC = 2'h1;
  localparam logic [3:0] TC_CMP_SPECIAL_EVENT = 4'hB;
  localparam logic [15:0] TC_CNT_MAX = 16'hFFFF;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic wide_access_enable;
    logic sysclk_from_timer_osc;
    logic [1:0] prescale_select;
    logic osc_enable;
    logic sync_bypass;
    logic clock_source_select;
    logic timer_on;
  } tc_ctrl_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tc_bus_req_t;

  typedef struct packed {
    logic [3:0] mode;
    logic match;
  } tc_cmp_evt_t;

endpackage

// ### rtl/tc_timer.sv
/*
  16-bit timer/counter with prescaler, external clock input, crystal
  oscillator controls, buffered 16-bit access and overflow flag.
  Assumes: one clock (the instruction-cycle clock), synchronous reset,
  compare-unit events arrive on this clock, pins and the clock mux
  status are asynchronous and sampled here.
*/
// Functional notes
// - Counting happens only while timer_on is set; clearing it holds the count.
// - Internal source counts every cycle; external source counts rising pin edges.
// - Prescale field divides input by 1, 2, 4 or 8.
// - External source is synchronised unless sync_bypass is set.
// - osc_enable turns the crystal amplifier and feedback on; off removes drain.
// - wide_access_enable selects buffered 16-bit or plain 8-bit byte access.
// - Status bit 6 reads one while system clock comes from timer oscillator.
// - Wide mode low-byte read copies live high byte into the buffer.
// - Wide mode low-byte write loads live high byte from buffer together.
// - High-byte writes keep prescaler; low-byte writes clear it.
// - While timer on, both pins are inputs and read back as zero.
// - Count wraps FFFF to 0000 and the wrap sets the overflow flag.
// - Interrupt request appears only while the overflow enable is set.
// - Oscillator enable is independent of any power-managed mode.
// - System clock select 01 requests clocking from the timer oscillator.
// - Configuration strap picks low or high drive; unprogrammed means high.
// - Compare special event trigger (mode 1011) clears the count, except when the external source runs with sync_bypass set.
// - A software count write wins over a coinciding trigger reset.
// - Trigger resets never set the overflow flag.
`timescale 1ns/100ps
module tc_timer
(
  input wire logic clock,
  input wire logic srst,
  input wire tc_pkg::tc_bus_req_t bus_req,
  output logic [7:0] rdata_q,
  output logic irq_q,
  input wire tc_pkg::tc_cmp_evt_t cmp1_evt,
  input wire tc_pkg::tc_cmp_evt_t cmp2_evt,
  input wire logic [1:0] pin_in,
  output logic [1:0] pin_out_q,
  output logic [1:0] pin_oe_n_q,
  output logic osc_amp_en_q,
  output logic osc_high_drive_q,
  input wire logic osc_low_power_config,
  output logic sysclk_sel_timer_osc_q,
  input wire logic sysclk_src_timer_osc
);
  import tc_pkg::*;

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  function automatic logic [2:0] ps_limit(input logic [1:0] sel);
    case (sel)
      2'h0: ps_limit = 3'h0;
      2'h1: ps_limit = 3'h1;
      2'h2: ps_limit = 3'h3;
      default: ps_limit = 3'h7;
    endcase
  endfunction

  function automatic logic is_special(input tc_cmp_evt_t e);
    is_special = e.match && (e.mode == TC_CMP_SPECIAL_EVENT);
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  tc_ctrl_t ctrl_q;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [7:0] hi_buf_q;
  logic [2:0] ps_cnt_q;
  logic [2:0] ps_cnt_d;
  logic ovf_flag_q;
  logic ovf_en_q;
  logic [1:0] scs_q;
  logic [1:0] dir_q;
  logic [1:0] latch_q;
  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;
  logic ext_prev_q;
  logic edge_s1_q;
  logic edge_s2_q;
  logic run_s1_q;
  logic run_s2_q;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire wr_ctrl = bus_req.wr && (bus_req.addr == TC_OFS_CTRL);
  wire wr_lo = bus_req.wr && (bus_req.addr == TC_OFS_CNT_LO);
  wire wr_hi = bus_req.wr && (bus_req.addr == TC_OFS_CNT_HI);
  wire wr_flags = bus_req.wr && (bus_req.addr == TC_OFS_IRQ_FLAGS);
  wire wr_en = bus_req.wr && (bus_req.addr == TC_OFS_IRQ_ENABLES);
  wire wr_osc = bus_req.wr && (bus_req.addr == TC_OFS_OSC_CTRL);
  wire wr_dir = bus_req.wr && (bus_req.addr == TC_OFS_PORT_DIR);
  wire wr_data = bus_req.wr && (bus_req.addr == TC_OFS_PORT_DATA);
  wire rd_lo = bus_req.rd && (bus_req.addr == TC_OFS_CNT_LO);
  wire wide = ctrl_q.wide_access_enable;
  wire cnt_wr = wr_lo || (wr_hi && !wide);

  // ---------------------------------------------------------------
  // Count source
  // ---------------------------------------------------------------
  wire ext_rise = pin_s2_q[0] && !ext_prev_q;
  wire async_mode = ctrl_q.clock_source_select && ctrl_q.sync_bypass;
  wire src_tick = !ctrl_q.clock_source_select ? 1'b1 :
                  (ctrl_q.sync_bypass ? ext_rise : edge_s2_q);
  wire tick = ctrl_q.timer_on && src_tick;
  wire inc = tick && (ps_cnt_q >= ps_limit(ctrl_q.prescale_select));
  wire trig = (is_special(cmp1_evt) || is_special(cmp2_evt)) && !async_mode;
  wire wrap = inc && !cnt_wr && !trig && (cnt_q == TC_CNT_MAX);

  // ---------------------------------------------------------------
  // Counter next value
  // ---------------------------------------------------------------
  always_comb
  begin
    cnt_d = cnt_q;
    if (wr_lo)
    begin
      cnt_d = {wide ? hi_buf_q : cnt_q[15:8], bus_req.wdata};
    end
    else if (wr_hi && !wide)
    begin
      cnt_d = {bus_req.wdata, cnt_q[7:0]};
    end
    else if (trig)
    begin
      cnt_d = 16'h0000;
    end
    else if (inc)
    begin
      cnt_d = 16'(cnt_q + 16'h0001);
    end
  end

  always_comb
  begin
    ps_cnt_d = ps_cnt_q;
    if (wr_lo || trig)
    begin
      ps_cnt_d = 3'h0;
    end
    else if (inc)
    begin
      ps_cnt_d = 3'h0;
    end
    else if (tick)
    begin
      ps_cnt_d = 3'(ps_cnt_q + 3'h1);
    end
  end

  // ---------------------------------------------------------------
  // Input sampling
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    pin_s1_q <= pin_in;
    pin_s2_q <= pin_s1_q;
    run_s1_q <= sysclk_src_timer_osc;
    run_s2_q <= run_s1_q;
    ext_prev_q <= pin_s2_q[0];
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      edge_s1_q <= 1'b0;
      edge_s2_q <= 1'b0;
    end
    else
    begin
      edge_s1_q <= ext_rise;
      edge_s2_q <= edge_s1_q;
    end
  end

  // ---------------------------------------------------------------
  // Counter, prescaler and buffer
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      cnt_q <= 16'h0000;
      ps_cnt_q <= 3'h0;
      hi_buf_q <= 8'h00;
    end
    else
    begin
      cnt_q <= cnt_d;
      ps_cnt_q <= ps_cnt_d;
      if (rd_lo && wide)
        hi_buf_q <= cnt_q[15:8];
      else if (wr_hi && wide)
        hi_buf_q <= bus_req.wdata;
    end
  end

  // ---------------------------------------------------------------
  // Control and side registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ctrl_q <= TC_CTRL_RST;
      ovf_en_q <= 1'b0;
      scs_q <= TC_SCS_RST;
      dir_q <= TC_DIR_RST;
      latch_q <= 2'h0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl_q <= bus_req.wdata;
        ctrl_q.sysclk_from_timer_osc <= 1'b0;
      end
      if (wr_en)
        ovf_en_q <= bus_req.wdata[TC_BIT_OVF];
      if (wr_osc)
        scs_q <= bus_req.wdata[1:0];
      if (wr_dir)
        dir_q <= bus_req.wdata[1:0];
      if (wr_data)
        latch_q <= bus_req.wdata[1:0];
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      ovf_flag_q <= 1'b0;
    else if (wrap)
      ovf_flag_q <= 1'b1;
    else if (wr_flags)
      ovf_flag_q <= bus_req.wdata[TC_BIT_OVF];
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  tc_ctrl_t ctrl_rd;
  logic [7:0] rd_mux;
  always_comb
  begin
    ctrl_rd = ctrl_q;
    ctrl_rd.sysclk_from_timer_osc = run_s2_q;
    case (bus_req.addr)
      TC_OFS_CTRL: rd_mux = ctrl_rd;
      TC_OFS_CNT_LO: rd_mux = cnt_q[7:0];
      TC_OFS_CNT_HI: rd_mux = wide ? hi_buf_q : cnt_q[15:8];
      TC_OFS_IRQ_FLAGS: rd_mux = {7'h00, ovf_flag_q};
      TC_OFS_IRQ_ENABLES: rd_mux = {7'h00, ovf_en_q};
      TC_OFS_OSC_CTRL: rd_mux = {6'h00, scs_q};
      TC_OFS_PORT_DIR: rd_mux = {6'h00, dir_q};
      TC_OFS_PORT_DATA: rd_mux = {6'h00,
                                  ctrl_q.timer_on ? 2'h0 : pin_s2_q};
      default: rd_mux = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
      pin_out_q <= 2'h0;
      pin_oe_n_q <= 2'h3;
      osc_amp_en_q <= 1'b0;
      osc_high_drive_q <= 1'b1;
      sysclk_sel_timer_osc_q <= 1'b0;
    end
    else
    begin
      rdata_q <= bus_req.rd ? rd_mux : 8'h00;
      irq_q <= ovf_flag_q && ovf_en_q;
      pin_out_q <= latch_q;
      pin_oe_n_q <= ctrl_q.timer_on ? 2'h3 : dir_q;
      osc_amp_en_q <= ctrl_q.osc_enable;
      osc_high_drive_q <= !osc_low_power_config;
      sysclk_sel_timer_osc_q <= (scs_q == TC_SCS_TIMER_OSC);
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_hold_off;
    @(posedge clock) disable iff (srst)
    !ctrl_q.timer_on && !cnt_wr && !trig |=> $stable(cnt_q);
  endproperty
  a_hold_off: assert property (p_hold_off)
    else $error("count moved while timer off");

  property p_prescale;
    @(posedge clock) disable iff (srst)
    inc && !cnt_wr && !trig |=> cnt_q == 16'($past(cnt_q) + 16'h0001);
  endproperty
  a_prescale: assert property (p_prescale)
    else $error("prescaler terminal count did not advance count");

  property p_snapshot;
    @(posedge clock) disable iff (srst)
    rd_lo && wide |=> hi_buf_q == $past(cnt_q[15:8]);
  endproperty
  a_snapshot: assert property (p_snapshot)
    else $error("high buffer not loaded on low read");

  property p_atomic;
    @(posedge clock) disable iff (srst)
    wr_lo && wide |=> cnt_q == {$past(hi_buf_q), $past(bus_req.wdata)};
  endproperty
  a_atomic: assert property (p_atomic)
    else $error("wide write not atomic");

  property p_ps_clear;
    @(posedge clock) disable iff (srst)
    wr_lo ##1 !tick |-> ps_cnt_q == 3'h0;
  endproperty
  a_ps_clear: assert property (p_ps_clear)
    else $error("prescaler not cleared by low write");

  property p_pins_in;
    @(posedge clock) disable iff (srst)
    ctrl_q.timer_on |=> pin_oe_n_q == 2'h3;
  endproperty
  a_pins_in: assert property (p_pins_in)
    else $error("pin driven while timer on");

  property p_wrap;
    @(posedge clock) disable iff (srst)
    wrap |=> ovf_flag_q && cnt_q == 16'h0000 ##1 irq_q == ovf_en_q;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("wrap did not clear count or set flag");

  property p_mask;
    @(posedge clock) disable iff (srst)
    !ovf_en_q [*2] |-> !irq_q;
  endproperty
  a_mask: assert property (p_mask)
    else $error("request while masked");

  property p_trig;
    @(posedge clock) disable iff (srst)
    trig && !cnt_wr |=> cnt_q == 16'h0000 && ovf_flag_q == $past(ovf_flag_q)
      || $past(wr_flags);
  endproperty
  a_trig: assert property (p_trig)
    else $error("trigger did not clear count or touched flag");

  property p_write_wins;
    @(posedge clock) disable iff (srst)
    trig && wr_lo |=> cnt_q[7:0] == $past(bus_req.wdata);
  endproperty
  a_write_wins: assert property (p_write_wins)
    else $error("trigger overrode write");

  property p_osc;
    @(posedge clock) disable iff (srst)
    ctrl_q.osc_enable [*2] |-> osc_amp_en_q;
  endproperty
  a_osc: assert property (p_osc)
    else $error("oscillator amplifier off while enabled");

endmodule

// ### verif/sixteen_bit_timer_counter_with_osc_tb.sv
/*
  Self-checking bench of the timer/counter over its register port.
  Assumes the package constants and the clock source model.
*/
`timescale 1ns/100ps
module sixteen_bit_timer_counter_with_osc_tb;
  import tc_pkg::*;

  logic clock;
  logic srst;
  tc_bus_req_t bus_req;
  tc_cmp_evt_t cmp1_evt;
  tc_cmp_evt_t cmp2_evt;
  logic [1:0] pin_in;
  logic [7:0] rdata_q;
  logic irq_q;
  logic [1:0] pin_out_q;
  logic [1:0] pin_oe_n_q;
  logic osc_amp_en_q;
  logic osc_high_drive_q;
  logic osc_low_power_config;
  logic sysclk_sel_timer_osc_q;
  logic sysclk_src_timer_osc;
  logic run;
  logic [7:0] v;
  int n_mismatch = 0;
  int n_compared = 0;

  tc_timer DUT (.clock(clock), .srst(srst), .bus_req(bus_req),
    .rdata_q(rdata_q), .irq_q(irq_q), .cmp1_evt(cmp1_evt),
    .cmp2_evt(cmp2_evt), .pin_in(pin_in), .pin_out_q(pin_out_q),
    .pin_oe_n_q(pin_oe_n_q), .osc_amp_en_q(osc_amp_en_q),
    .osc_high_drive_q(osc_high_drive_q),
    .osc_low_power_config(osc_low_power_config),
    .sysclk_sel_timer_osc_q(sysclk_sel_timer_osc_q),
    .sysclk_src_timer_osc(sysclk_src_timer_osc));

  tc_ext_clk src (.clock(clock), .run(run), .pin(pin_in));

  // ---------------------------------------------------------------
  // Bus tasks and comparison
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      n_mismatch++;
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus_req <= '0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus_req <= '0;
    @(posedge clock);
    d = rdata_q;
  endtask

  task automatic rc(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  // Low byte advance over a fixed window
  task automatic rate(input logic [7:0] ctl, input int gap,
    input logic [7:0] exp);
    logic [7:0] a;
    logic [7:0] b;
    wr(TC_OFS_CTRL, ctl);
    repeat (20) @(posedge clock);
    rd(TC_OFS_CNT_LO, a);
    repeat (gap) @(posedge clock);
    rd(TC_OFS_CNT_LO, b);
    chk(b - a, exp);
    wr(TC_OFS_CTRL, 8'h00);
  endtask

  task automatic trig(input int unit, input logic [3:0] m);
    if (unit == 1)
      cmp1_evt <= '{mode: m, match: 1'b1};
    else
      cmp2_evt <= '{mode: m, match: 1'b1};
    @(posedge clock);
    bus_req <= '0;
    cmp1_evt <= '0;
    cmp2_evt <= '0;
    @(posedge clock);
  endtask

  task automatic summarize;
    if (n_mismatch == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Clock, reset and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    summarize();
  end

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial
  begin
    srst = 1'b1;
    bus_req = '0;
    cmp1_evt = '0;
    cmp2_evt = '0;
    run = 1'b0;
    osc_low_power_config = 1'b0;
    sysclk_src_timer_osc = 1'b0;
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    rc(TC_OFS_CTRL, 8'h00);
    rc(TC_OFS_PORT_DIR, 8'h03);
    chk({6'h0, pin_oe_n_q}, 8'h03);
    chk({7'h0, osc_high_drive_q}, 8'h01);
    wr(TC_OFS_CTRL, 8'h40);
    rc(TC_OFS_CTRL, 8'h00);
    sysclk_src_timer_osc <= 1'b1;
    repeat (4) @(posedge clock);
    rc(TC_OFS_CTRL, 8'h40);
    sysclk_src_timer_osc <= 1'b0;
    wr(TC_OFS_OSC_CTRL, 8'h01);
    // Output flop updates one edge after the register
    @(posedge clock);
    chk({7'h0, sysclk_sel_timer_osc_q}, 8'h01);
    wr(TC_OFS_CTRL, 8'h08);
    @(posedge clock);
    chk({7'h0, osc_amp_en_q}, 8'h01);
    wr(TC_OFS_CTRL, 8'h00);
    @(posedge clock);
    chk({7'h0, osc_amp_en_q}, 8'h00);
    osc_low_power_config <= 1'b1;
    repeat (3) @(posedge clock);
    chk({7'h0, osc_high_drive_q}, 8'h00);
    // Buffered access against byte access
    wr(TC_OFS_CTRL, 8'h80);
    wr(TC_OFS_CNT_HI, 8'h12);
    wr(TC_OFS_CNT_LO, 8'h34);
    rc(TC_OFS_CNT_LO, 8'h34);
    rc(TC_OFS_CNT_HI, 8'h12);
    wr(TC_OFS_CTRL, 8'h00);
    wr(TC_OFS_CNT_HI, 8'h56);
    rc(TC_OFS_CNT_HI, 8'h56);
    wr(TC_OFS_CTRL, 8'h80);
    rc(TC_OFS_CNT_HI, 8'h12);
    rc(TC_OFS_CNT_LO, 8'h34);
    rc(TC_OFS_CNT_HI, 8'h56);
    // Internal source, every prescale code
    rate(8'h01, 62, 8'h40);
    rate(8'h11, 62, 8'h20);
    rate(8'h21, 62, 8'h10);
    rate(8'h31, 62, 8'h08);
    // External source, synchronised and not
    run <= 1'b1;
    rate(8'h0B, 98, 8'h0A);
    rate(8'h0F, 98, 8'h0A);
    rate(8'h1B, 98, 8'h05);
    run <= 1'b0;
    // Wrap, flag and request masking
    wr(TC_OFS_CNT_HI, 8'hFF);
    wr(TC_OFS_CNT_LO, 8'hF0);
    wr(TC_OFS_IRQ_ENABLES, 8'h01);
    wr(TC_OFS_CTRL, 8'h01);
    for (int i = 0; i < 100 && irq_q !== 1'b1; i++)
      @(posedge clock);
    chk({7'h0, irq_q}, 8'h01);
    wr(TC_OFS_CTRL, 8'h00);
    rc(TC_OFS_CNT_HI, 8'h00);
    rc(TC_OFS_IRQ_FLAGS, 8'h01);
    rd(TC_OFS_CNT_LO, v);
    repeat (10) @(posedge clock);
    rc(TC_OFS_CNT_LO, v);
    wr(TC_OFS_IRQ_ENABLES, 8'h00);
    @(posedge clock);
    chk({7'h0, irq_q}, 8'h00);
    wr(TC_OFS_IRQ_FLAGS, 8'h00);
    rc(TC_OFS_IRQ_FLAGS, 8'h00);
    // Compare unit triggers
    wr(TC_OFS_CNT_HI, 8'h12);
    wr(TC_OFS_CTRL, 8'h31);
    trig(1, 4'h2);
    rc(TC_OFS_CNT_HI, 8'h12);
    trig(1, TC_CMP_SPECIAL_EVENT);
    rc(TC_OFS_CNT_HI, 8'h00);
    // Trigger lands on the FFFF cycle that would otherwise wrap
    wr(TC_OFS_CTRL, 8'h01);
    wr(TC_OFS_CNT_HI, 8'hFF);
    wr(TC_OFS_CNT_LO, 8'hFE);
    trig(2, TC_CMP_SPECIAL_EVENT);
    wr(TC_OFS_CTRL, 8'h00);
    rc(TC_OFS_CNT_HI, 8'h00);
    rc(TC_OFS_IRQ_FLAGS, 8'h00);
    bus_req <= '{addr: TC_OFS_CNT_LO, wdata: 8'h55, wr: 1'b1, rd: 1'b0};
    trig(1, TC_CMP_SPECIAL_EVENT);
    rc(TC_OFS_CNT_LO, 8'h55);
    // Pin direction override
    wr(TC_OFS_PORT_DIR, 8'h00);
    wr(TC_OFS_PORT_DATA, 8'h01);
    repeat (3) @(posedge clock);
    chk({6'h0, pin_oe_n_q}, 8'h00);
    chk({6'h0, pin_out_q}, 8'h01);
    rc(TC_OFS_PORT_DATA, 8'h02);
    wr(TC_OFS_CTRL, 8'h01);
    repeat (2) @(posedge clock);
    chk({6'h0, pin_oe_n_q}, 8'h03);
    rc(TC_OFS_PORT_DATA, 8'h00);
    wr(TC_OFS_CTRL, 8'h00);
    summarize();
  end
endmodule

// ### verif/tc_ext_clk.sv
/*
  Model of the clock source at the timer pin pair.
  Assumes the bench clock; pin edges fall on its falling edges.
*/
`timescale 1ns/100ps
module tc_ext_clk
(
  clock,
  run,
  pin
);
  input wire logic clock;
  input wire logic run;
  output logic [1:0] pin;

  logic [2:0] cnt_q = 3'h0;
  logic lvl_q = 1'b0;

  // ---------------------------------------------------------------
  // Square wave, period ten cycles, low while stopped
  // ---------------------------------------------------------------
  // Inverter pair: in pin is the complement of out pin
  assign pin = {~lvl_q, lvl_q};

  always @(negedge clock)
  begin
    if (!run)
    begin
      cnt_q <= 3'h0;
      lvl_q <= 1'b0;
    end
    else if (cnt_q == 3'h4)
    begin
      cnt_q <= 3'h0;
      lvl_q <= ~lvl_q;
    end
    else
      cnt_q <= cnt_q + 3'h1;
  end
endmodule
